// ===== logic/bsps_slave.sv
// Purpose: Slave packet handler for the binary master-slave serial protocol.
// Assumes: Parameter values live outside; a set is a one-cycle write pulse.
// Notes:   Bytes are raw binary; one response per accepted command packet.
//          Bytes that arrive while a reply is going out are dropped.
`default_nettype none
// Contract
// [R1] Packet bytes are raw binary, never text hex digits.
// [R2] Master starts each transaction; slave sends exactly one response.
// [R3] Link runs 9600 baud, 8 data bits, 1 stop, no parity.
// [R4] Slave ignores the link unless serial communication is enabled.
// [R5] Master waits for the whole response before the next command.
// [R6] Bad command or checksum gets an error packet, else requested data.
// [R7] Master resends a command unanswered within one second.
// [R8] Every packet starts CA, then address bytes 00 and 01.
// [R9] Then command, count 00 to 03, data bytes, checksum.
// [R10] A qualifier byte counts as data and comes first.
// [R11] Reads carry count zero followed directly by checksum.
// [R12] Read reply echoes lead, address and command, then count, data, checksum.
// [R13] Reply data is qualifier then signed 16-bit value, high byte first.
// [R14] Checksum is inverted low byte of sum from address high to data.
// [R15] Set commands carry only two value bytes, no qualifier.
// [R16] Error reply uses 0F, two data bytes: code 01/03 and command echo.
// [R17] Qualifier 10, 20, 11 mean 0.1, 0.01, 0.1 degrees Celsius.
// [R18] Read codes 20,21,70,40,60,71-73; sets add 80; 00 acknowledges. Code has no set for 20 and 21.
// [R19] Skip bytes before a lead marker; drop partial packets after timeout.
module bsps_slave
	import bsps_pkg::*;
#(
	parameter int unsigned BIT_CYCLES   = BSPS_BIT_CYCLES,
	parameter int unsigned RETRY_CYCLES = BSPS_RETRY_CYCLES,
	parameter logic [15:0] VERSION      = 16'h0101 // arbitrary version value
) (
	input  wire logic                          I_CORE_CLK,   // 200 MHz core clock
	input  wire logic                          I_RST_B,      // synchronous reset, active low
	input  wire logic                          I_COMM_EN,    // serial communication switched on
	input  wire logic                          I_RXD,        // serial line from master
	output logic                               O_TXD,        // serial line to master
	input  wire logic [BSPS_NUM_PARAMS*16-1:0] I_PARAM_VAL,  // parameter values, index per read code
	input  wire logic [BSPS_NUM_PARAMS*8-1:0]  I_PARAM_QUAL, // qualifier per parameter
	output logic                               O_SET_STB,    // one-cycle set pulse
	output logic [2:0]                         O_SET_IDX,    // parameter index being set
	output logic [15:0]                        O_SET_VAL     // value being set
);
	typedef enum logic [2:0] {
		BSPS_S_LEAD  = 3'b000,
		BSPS_S_AHI   = 3'b001,
		BSPS_S_ALO   = 3'b010,
		BSPS_S_CMD   = 3'b011,
		BSPS_S_CNT   = 3'b100,
		BSPS_S_DATA  = 3'b101,
		BSPS_S_SUM   = 3'b110,
		BSPS_S_REPLY = 3'b111
	} bsps_state_t;

	localparam logic [7:0] CODES [BSPS_NUM_PARAMS] = '{8'h20, 8'h21, 8'h70, 8'h40, 8'h60, 8'h71, 8'h72, 8'h73};

	bsps_state_t state, next_state;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        tx_ready;
	logic [7:0]  cmd, next_cmd;
	logic [7:0]  cnt, next_cnt;
	logic [1:0]  dcnt, next_dcnt;
	logic [7:0]  sum, next_sum;
	logic [15:0] val, next_val;
	logic [31:0] tmo, next_tmo;
	logic [7:0]  resp [9];
	logic [7:0]  next_resp [9];
	logic [3:0]  rlen, next_rlen;
	logic [3:0]  ridx, next_ridx;
	logic        next_set_stb;
	logic [2:0]  next_set_idx;
	logic [15:0] next_set_val;
	logic [BSPS_NUM_PARAMS-1:0] hit_rd, hit_set;
	logic [2:0]  hit_idx;
	logic        cmd_rd, cmd_set;
	logic [7:0]  rep_cmd;
	logic [7:0]  rep_cnt;
	logic [7:0]  rep_d [3];
	logic [7:0]  rep_sum;
	logic        rep_set;
	logic        tmo_hit;
	logic        pkt_end;
	logic [7:0]  tx_byte;
	logic        tx_valid;

	bsps_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
		.i_clk   (I_CORE_CLK),
		.i_rst_b (I_RST_B),
		.i_rxd   (I_RXD),
		.o_valid (rx_valid),
		.o_data  (rx_data)
	);

	bsps_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
		.i_clk   (I_CORE_CLK),
		.i_rst_b (I_RST_B),
		.i_valid (tx_valid),
		.i_data  (tx_byte),
		.o_ready (tx_ready),
		.o_txd   (O_TXD)
	);

	// Decode the command against the read and set code tables. [R18]
	genvar g;
	generate
		for (g = 0; g < BSPS_NUM_PARAMS; g++) begin : g_dec
			assign hit_rd[g]  = (cmd == CODES[g]);
			assign hit_set[g] = (cmd == (CODES[g] + BSPS_SET_OFFSET)) && (CODES[g] != 8'h21) && (CODES[g] != 8'h20);
		end
	endgenerate

	always_comb begin
		hit_idx = 3'h0;
		for (int i = 0; i < BSPS_NUM_PARAMS; i++) begin
			if (hit_rd[i] || hit_set[i]) begin
				hit_idx = 3'(i);
			end
		end
	end

	// Reads take count zero, sets take two value bytes only. [R11] [R15]
	assign cmd_rd  = (|hit_rd) && (cnt == 8'h00);
	assign cmd_set = (|hit_set) && (cnt == 8'h02);
	assign tx_valid = (state == BSPS_S_REPLY) && (ridx < rlen);
	// The index runs one past the last byte while the final character is still being sent.
	// That slot is never offered, so a fixed byte keeps the data port defined.
	assign tx_byte  = (ridx < 4'h9) ? resp[ridx] : 8'h00;
	// Retry interval expired while a packet was still open.
	assign tmo_hit  = (state != BSPS_S_LEAD) && (state != BSPS_S_REPLY) && (tmo >= 32'(RETRY_CYCLES));
	// Checksum byte taken: the packet is complete this cycle.
	assign pkt_end  = (state == BSPS_S_SUM) && rx_valid && I_COMM_EN && !tmo_hit;

	// Reply body for the packet that the checksum byte closes.
	// The checksum is judged first, so a bad sum wins over an unknown command.
	// Any command that is neither a read, a set nor the acknowledge falls through to bad command.
	always_comb begin
		rep_cmd  = BSPS_CMD_ERROR; // [R6] [R16]
		rep_cnt  = BSPS_ERR_COUNT;
		rep_d[0] = BSPS_ERR_BADCMD;
		rep_d[1] = cmd;
		rep_d[2] = 8'h00;
		rep_set  = 1'b0;
		if (rx_data != ~sum) begin // [R14]
			rep_d[0] = BSPS_ERR_BADSUM; // [R6] [R16]
		end else if (cmd == BSPS_CMD_ACK && cnt == 8'h00) begin // [R18]
			rep_cmd  = BSPS_CMD_ACK;
			rep_d[0] = VERSION[15:8];
			rep_d[1] = VERSION[7:0];
		end else if (cmd_rd || cmd_set) begin
			// Qualifier first, then value high byte first. [R10] [R13] [R17]
			rep_cmd  = cmd;
			rep_cnt  = BSPS_RESP_COUNT;
			rep_d[0] = I_PARAM_QUAL[hit_idx*8 +: 8];
			rep_d[1] = cmd_set ? val[15:8] : I_PARAM_VAL[hit_idx*16+8 +: 8];
			rep_d[2] = cmd_set ? val[7:0] : I_PARAM_VAL[hit_idx*16 +: 8];
			rep_set  = cmd_set;
		end
		// The lead marker stays out of the sum. [R14]
		rep_sum = BSPS_ADDR_HI + BSPS_ADDR_LO + rep_cmd + rep_cnt + rep_d[0] + rep_d[1];
		if (rep_cnt == BSPS_RESP_COUNT) begin
			rep_sum = rep_sum + rep_d[2];
		end
	end

	always_comb begin
		next_state   = state;
		next_cmd     = cmd;
		next_cnt     = cnt;
		next_dcnt    = dcnt;
		next_sum     = sum;
		next_val     = val;
		next_tmo     = tmo;
		next_resp    = resp;
		next_rlen    = rlen;
		next_ridx    = ridx;
		// The retry counter runs only while a packet is open; a lead marker clears it.
		if (state != BSPS_S_LEAD && state != BSPS_S_REPLY) begin
			next_tmo = tmo + 32'h1;
		end
		// A stale partial packet is dropped once the retry interval runs out. [R19]
		if (tmo_hit) begin
			next_state = BSPS_S_LEAD;
		end else if (state == BSPS_S_REPLY) begin
			// Bytes arriving during the reply are dropped; the link is half duplex.
			// Exactly one response, sent byte by byte as binary. [R1] [R2]
			if (tx_ready && ridx < rlen) begin
				next_ridx = ridx + 4'h1;
			end else if (tx_ready && ridx == rlen) begin
				next_state = BSPS_S_LEAD;
			end
		end else if (rx_valid && I_COMM_EN) begin // [R4]
			next_sum = sum + rx_data;
			unique case (state)
				BSPS_S_LEAD: begin
					// Bytes before a lead marker are discarded. [R19] [R8]
					if (rx_data == BSPS_LEAD) begin
						next_state = BSPS_S_AHI;
						next_sum   = 8'h00;
						next_tmo   = 32'h0;
					end
				end
				BSPS_S_AHI: next_state = (rx_data == BSPS_ADDR_HI) ? BSPS_S_ALO : BSPS_S_LEAD; // [R8]
				BSPS_S_ALO: next_state = (rx_data == BSPS_ADDR_LO) ? BSPS_S_CMD : BSPS_S_LEAD; // [R8]
				BSPS_S_CMD: begin
					next_cmd   = rx_data;
					next_state = BSPS_S_CNT;
				end
				BSPS_S_CNT: begin
					// Count limited to 00 through 03. [R9]
					next_cnt  = rx_data;
					next_dcnt = 2'h0;
					if (rx_data > BSPS_MAX_COUNT) begin
						next_state = BSPS_S_LEAD;
					end else begin
						next_state = (rx_data == 8'h00) ? BSPS_S_SUM : BSPS_S_DATA;
					end
				end
				BSPS_S_DATA: begin
					next_val  = {val[7:0], rx_data};
					next_dcnt = dcnt + 2'h1;
					if (8'(dcnt) + 8'h01 == cnt) begin
						next_state = BSPS_S_SUM;
					end
				end
				BSPS_S_SUM: begin
					// Echo lead and address, then the prepared reply body. [R12]
					next_state   = BSPS_S_REPLY;
					next_ridx    = 4'h0;
					next_resp[0] = BSPS_LEAD;
					next_resp[1] = BSPS_ADDR_HI;
					next_resp[2] = BSPS_ADDR_LO;
					next_resp[3] = rep_cmd;
					next_resp[4] = rep_cnt;
					next_resp[5] = rep_d[0];
					next_resp[6] = rep_d[1];
					if (rep_cnt == BSPS_RESP_COUNT) begin
						next_resp[7] = rep_d[2];
						next_resp[8] = ~rep_sum; // [R14]
						next_rlen    = 4'h9;
					end else begin
						next_resp[7] = ~rep_sum; // [R14]
						next_rlen    = 4'h8;
					end
				end
				default: next_state = BSPS_S_LEAD;
			endcase
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			state     <= BSPS_S_LEAD;
			cmd       <= BSPS_RESET_BYTE;
			cnt       <= BSPS_RESET_BYTE;
			dcnt      <= 2'h0;
			sum       <= BSPS_RESET_BYTE;
			val       <= 16'h0000;
			tmo       <= 32'h0;
			resp      <= '{default: 8'h00};
			rlen      <= 4'h0;
			ridx      <= 4'h0;
		end else begin
			state     <= next_state;
			cmd       <= next_cmd;
			cnt       <= next_cnt;
			dcnt      <= next_dcnt;
			sum       <= next_sum;
			val       <= next_val;
			tmo       <= next_tmo;
			resp      <= next_resp;
			rlen      <= next_rlen;
			ridx      <= next_ridx;
		end
	end

	// A valid set pulses once, together with the reply it earns. [R15]
	// Index and value hold until the next set so a slow consumer can still read them.
	always_comb begin
		next_set_stb = 1'b0;
		next_set_idx = O_SET_IDX;
		next_set_val = O_SET_VAL;
		if (pkt_end && rep_set) begin
			next_set_stb = 1'b1;
			next_set_idx = hit_idx;
			next_set_val = val;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_B) begin
			O_SET_STB <= BSPS_RESET_BIT;
			O_SET_IDX <= 3'h0;
			O_SET_VAL <= 16'h0000;
		end else begin
			O_SET_STB <= next_set_stb;
			O_SET_IDX <= next_set_idx;
			O_SET_VAL <= next_set_val;
		end
	end
endmodule
`default_nettype wire

// ===== logic/bsps_pkg.sv
// Purpose: Constants shared by the serial packet slave.
// Assumes: Byte stream delivered by a separate character receiver.
// Notes:   Bit and retry counts are cycles of the 200 MHz core clock.
`default_nettype none
package bsps_pkg;
	localparam logic [7:0]  BSPS_LEAD        = 8'hca;
	localparam logic [7:0]  BSPS_ADDR_HI     = 8'h00;
	localparam logic [7:0]  BSPS_ADDR_LO     = 8'h01;
	localparam logic [7:0]  BSPS_MAX_COUNT   = 8'h03;
	localparam logic [7:0]  BSPS_CMD_ERROR   = 8'h0f;
	localparam logic [7:0]  BSPS_CMD_ACK     = 8'h00;
	localparam logic [7:0]  BSPS_ERR_BADCMD  = 8'h01;
	localparam logic [7:0]  BSPS_ERR_BADSUM  = 8'h03;
	localparam logic [7:0]  BSPS_SET_OFFSET  = 8'h80;
	localparam logic [7:0]  BSPS_RESP_COUNT  = 8'h03;
	localparam logic [7:0]  BSPS_ERR_COUNT   = 8'h02;
	localparam logic [7:0]  BSPS_QUAL_P1     = 8'h10;
	localparam logic [7:0]  BSPS_QUAL_P01    = 8'h20;
	localparam logic [7:0]  BSPS_QUAL_P1_C   = 8'h11;
	localparam int unsigned BSPS_CLK_HZ      = 200000000;
	localparam int unsigned BSPS_BAUD        = 9600;
	localparam int unsigned BSPS_BIT_CYCLES  = BSPS_CLK_HZ / BSPS_BAUD;
	localparam int unsigned BSPS_RETRY_MS    = 1000;
	localparam int unsigned BSPS_RETRY_CYCLES = (BSPS_CLK_HZ / 1000) * BSPS_RETRY_MS;
	localparam int unsigned BSPS_NUM_PARAMS  = 8;
	localparam logic [7:0]  BSPS_RESET_BYTE  = 8'h00;
	localparam logic        BSPS_RESET_BIT   = 1'b0;
endpackage
`default_nettype wire

// ===== logic/bsps_uart_rx.sv
// Purpose: Receives 8N1 characters from the serial line.
// Assumes: Line input already synchronous to the core clock.
// Notes:   Samples mid-bit; a missing stop bit drops the character.
`default_nettype none
module bsps_uart_rx
	import bsps_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = BSPS_BIT_CYCLES
) (
	input  wire logic       i_clk,   // core clock
	input  wire logic       i_rst_b, // synchronous reset, active low
	input  wire logic       i_rxd,   // serial line, idle high
	output logic            o_valid, // one-cycle pulse per character
	output logic [7:0]      o_data   // received character
);
	logic        busy, next_busy;
	logic [15:0] cnt, next_cnt;
	logic [3:0]  bitn, next_bitn;
	logic [7:0]  shreg, next_shreg;
	logic        next_valid;
	logic [7:0]  next_data;

	// Start, eight data bits LSB first and one stop bit, no parity. [R3]
	always_comb begin
		next_busy  = busy;
		next_cnt   = cnt;
		next_bitn  = bitn;
		next_shreg = shreg;
		next_valid = 1'b0;
		next_data  = o_data;
		if (!busy) begin
			if (!i_rxd) begin
				next_busy = 1'b1;
				next_cnt  = 16'(BIT_CYCLES / 2);
				next_bitn = 4'h0;
			end
		end else if (cnt != 16'h0000) begin
			next_cnt = cnt - 16'h0001;
		end else begin
			next_cnt  = 16'(BIT_CYCLES - 1);
			next_bitn = bitn + 4'h1;
			if (bitn == 4'h0) begin
				if (i_rxd) begin
					next_busy = 1'b0;
				end
			end else if (bitn < 4'h9) begin
				next_shreg = {i_rxd, shreg[7:1]};
			end else begin
				next_busy = 1'b0;
				if (i_rxd) begin
					next_valid = 1'b1;
					next_data  = shreg;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			busy    <= BSPS_RESET_BIT;
			cnt     <= 16'h0000;
			bitn    <= 4'h0;
			shreg   <= BSPS_RESET_BYTE;
			o_valid <= BSPS_RESET_BIT;
			o_data  <= BSPS_RESET_BYTE;
		end else begin
			busy    <= next_busy;
			cnt     <= next_cnt;
			bitn    <= next_bitn;
			shreg   <= next_shreg;
			o_valid <= next_valid;
			o_data  <= next_data;
		end
	end
endmodule
`default_nettype wire

// ===== logic/bsps_uart_tx.sv
// Purpose: Sends 8N1 characters on the serial line.
// Assumes: One character is offered at a time with valid and ready.
// Notes:   Line idles high from reset.
`default_nettype none
module bsps_uart_tx
	import bsps_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = BSPS_BIT_CYCLES
) (
	input  wire logic       i_clk,   // core clock
	input  wire logic       i_rst_b, // synchronous reset, active low
	input  wire logic       i_valid, // character offered
	input  wire logic [7:0] i_data,  // character to send
	output logic            o_ready, // idle, takes character this cycle
	output logic            o_txd    // serial line out
);
	logic        busy, next_busy;
	logic [15:0] cnt, next_cnt;
	logic [3:0]  bitn, next_bitn;
	logic [9:0]  frame, next_frame;
	logic        next_txd;

	assign o_ready = !busy;

	// Frame is start bit, eight data bits, stop bit. [R3]
	always_comb begin
		next_busy  = busy;
		next_cnt   = cnt;
		next_bitn  = bitn;
		next_frame = frame;
		next_txd   = o_txd;
		if (!busy) begin
			next_txd = 1'b1;
			if (i_valid) begin
				next_busy  = 1'b1;
				next_frame = {1'b1, i_data, 1'b0};
				next_cnt   = 16'(BIT_CYCLES - 1);
				next_bitn  = 4'h0;
				next_txd   = 1'b0;
			end
		end else if (cnt != 16'h0000) begin
			next_cnt = cnt - 16'h0001;
		end else if (bitn == 4'h9) begin
			next_busy = 1'b0;
			next_txd  = 1'b1;
		end else begin
			next_bitn = bitn + 4'h1;
			next_cnt  = 16'(BIT_CYCLES - 1);
			next_txd  = frame[4'(bitn + 4'h1)];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			busy  <= BSPS_RESET_BIT;
			cnt   <= 16'h0000;
			bitn  <= 4'h0;
			frame <= 10'h3ff;
			o_txd <= 1'b1;
		end else begin
			busy  <= next_busy;
			cnt   <= next_cnt;
			bitn  <= next_bitn;
			frame <= next_frame;
			o_txd <= next_txd;
		end
	end
endmodule
`default_nettype wire

// ===== verification/bsps_properties.sv
// Purpose: Port-level checks of the serial packet slave.
// Assumes: Synchronous active-low reset; one core clock.
// Notes:   Idle counters tell a quiet line from a frame in progress.
`default_nettype none
module bsps_properties #(
	parameter int unsigned BIT_CYCLES = 16
) (
	input  wire logic        I_CORE_CLK, // core clock
	input  wire logic        I_RST_B,    // reset, active low
	input  wire logic        I_COMM_EN,  // link enable
	input  wire logic        I_RXD,      // line from master
	input  wire logic        O_TXD,      // line to master
	input  wire logic        O_SET_STB,  // set pulse
	input  wire logic [2:0]  O_SET_IDX,  // set index
	input  wire logic [15:0] O_SET_VAL   // set value
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RST_B);
	int unsigned tq;
	int unsigned rq;
	int unsigned off;
	int unsigned next_tq;
	int unsigned next_rq;
	int unsigned next_off;
	always_comb begin
		next_tq = (O_TXD && tq < 100000) ? tq + 1 : (O_TXD ? tq : 0);
		next_rq = (I_RXD && rq < 100000) ? rq + 1 : (I_RXD ? rq : 0);
		next_off = (!I_COMM_EN && off < 100000) ? off + 1 : (I_COMM_EN ? 0 : off);
		if (!I_RST_B) begin
			next_tq = 0;
			next_rq = 0;
			next_off = 0;
		end
	end
	always_ff @(posedge I_CORE_CLK) begin
		tq <= next_tq;
		rq <= next_rq;
		off <= next_off;
	end
	a_reset_idle: assert property ($rose(I_RST_B) |-> O_TXD && !O_SET_STB && O_SET_VAL == 16'h0)
		else $error("outputs not at rest after reset");
	a_stb_single: assert property (O_SET_STB |=> !O_SET_STB)
		else $error("set pulse longer than one cycle");
	a_start_bit: assert property ($fell(O_TXD) |-> !O_TXD [*8])
		else $error("low bit shorter than expected");
	a_stb_reply: assert property (O_SET_STB |-> ##[0:16] !O_TXD)
		else $error("no reply after set");
	a_set_marked: assert property (($changed(O_SET_IDX) || $changed(O_SET_VAL)) |-> ##[0:1] O_SET_STB)
		else $error("set value changed without pulse");
	a_set_index: assert property (O_SET_STB |-> O_SET_IDX >= 3'h2)
		else $error("set on a read-only index");
	a_stb_enabled: assert property (O_SET_STB |-> $past(I_COMM_EN, 1))
		else $error("set while link disabled");
	a_quiet_off: assert property ((off > 32 && tq > 10 * BIT_CYCLES) |=> O_TXD)
		else $error("reply while link disabled");
	a_no_unasked: assert property (($fell(O_TXD) && tq > 10 * BIT_CYCLES) |-> rq < 12 * BIT_CYCLES)
		else $error("reply without a request");
	c_set: cover property (O_SET_STB);
	c_reply: cover property ($fell(O_TXD) && tq > 10 * BIT_CYCLES);
	c_off: cover property (off > 32 && tq > 10 * BIT_CYCLES);
endmodule
bind bsps_slave bsps_properties #(.BIT_CYCLES(BIT_CYCLES)) prop_u (
	.I_CORE_CLK(I_CORE_CLK),
	.I_RST_B(I_RST_B),
	.I_COMM_EN(I_COMM_EN),
	.I_RXD(I_RXD),
	.O_TXD(O_TXD),
	.O_SET_STB(O_SET_STB),
	.O_SET_IDX(O_SET_IDX),
	.O_SET_VAL(O_SET_VAL)
);
`default_nettype wire

// ===== verification/bsps_host_model.sv
// Purpose: Master side of the serial link.
// Assumes: Line idles high; inputs change at the falling edge.
// Notes:   Last stop bit is short so the reply start is never missed.
`default_nettype none
module bsps_host_model #(
	parameter int unsigned BIT = 16
) (
	input  wire logic i_clk, // core clock
	input  wire logic i_txd, // line from slave
	output var logic  o_rxd  // line to slave
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q [$];
	initial o_rxd = 1'b1;
	task automatic send(input logic [7:0] q [$]);
		logic [9:0] f;
		foreach (q[k]) begin
			f = {1'b1, q[k], 1'b0};
			for (int i = 0; i < 10; i++) begin
				@(negedge i_clk);
				o_rxd = f[i];
				repeat ((i == 9 && k == q.size() - 1) ? BIT / 4 : BIT - 1) @(negedge i_clk);
			end
		end
	endtask
	task automatic recv();
		logic [7:0] b;
		int t;
		bit got;
		rx_q.delete();
		got = 1'b1;
		while (got && (rx_q.size() < 5 || rx_q.size() < 6 + int'(rx_q[4])) && rx_q.size() < 9) begin
			t = 0;
			while (i_txd !== 1'b0 && t < 24 * BIT) begin
				@(negedge i_clk);
				t++;
			end
			got = (i_txd === 1'b0);
			if (got) begin
				repeat (BIT / 2) @(negedge i_clk);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT) @(negedge i_clk);
					b[i] = i_txd;
				end
				repeat (BIT) @(negedge i_clk);
				got = (i_txd === 1'b1);
				rx_q.push_back(b);
			end
		end
		repeat (BIT) @(negedge i_clk);
	endtask
endmodule
`default_nettype wire

// ===== verification/bsps_slave_tb_top.sv
// Purpose: Self-checking bench of the serial packet slave.
// Assumes: Short bit and retry counts keep the run brief.
// Notes:   Expected packets are built from the framing constants.
`default_nettype none
module bsps_slave_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bsps_pkg::*;
	localparam int unsigned BIT = 16;
	localparam int unsigned RETRY = 4000;
	localparam logic [15:0] VER = 16'h0a5c; // Arbitrary version value.
	typedef logic [7:0] bsps_bytes_t [$];
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        en = 1'b1;
	logic        rxd;
	logic        txd;
	logic        stb;
	logic [2:0]  idx;
	logic [15:0] sval;
	logic [127:0] pval;
	logic [63:0] pqual;
	int          mismatches = 0;
	int          checks = 0;
	int          stb_cnt = 0;
	always #2.5 clk = ~clk;
	bsps_slave #(.BIT_CYCLES(BIT), .RETRY_CYCLES(RETRY), .VERSION(VER)) dut_u (
		.I_CORE_CLK(clk),
		.I_RST_B(rst_b),
		.I_COMM_EN(en),
		.I_RXD(rxd),
		.O_TXD(txd),
		.I_PARAM_VAL(pval),
		.I_PARAM_QUAL(pqual),
		.O_SET_STB(stb),
		.O_SET_IDX(idx),
		.O_SET_VAL(sval)
	);
	bsps_host_model #(.BIT(BIT)) host_u (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
	always @(posedge clk) begin
		if (stb === 1'b1) stb_cnt++;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic bsps_bytes_t mk(input logic [7:0] c, input int n, input logic [23:0] d, input bit bad);
		bsps_bytes_t q;
		logic [7:0] s;
		q = {BSPS_LEAD, BSPS_ADDR_HI, BSPS_ADDR_LO, c, 8'(n)};
		for (int i = n - 1; i >= 0; i--) begin
			q.push_back(d[8*i+:8]);
		end
		s = 8'h00;
		foreach (q[i]) begin
			if (i > 0) s += q[i];
		end
		q.push_back(~s ^ {7'h00, bad});
		return q;
	endfunction
	task automatic xact(input bsps_bytes_t req, input bsps_bytes_t exp);
		host_u.send(req);
		host_u.recv();
		check(host_u.rx_q.size(), exp.size());
		foreach (exp[i]) check(host_u.rx_q[i], exp[i]);
	endtask
	function automatic bsps_bytes_t err(input logic [7:0] code, input logic [7:0] c);
		return mk(BSPS_CMD_ERROR, 2, {8'h00, code, c}, 1'b0);
	endfunction
	task automatic t_reads();
		logic [7:0] codes [8] = '{8'h20, 8'h21, 8'h70, 8'h40, 8'h60, 8'h71, 8'h72, 8'h73};
		foreach (codes[i]) begin
			xact(mk(codes[i], 0, 0, 0), mk(codes[i], 3, {pqual[8*i+:8], pval[16*i+:16]}, 0));
		end
		xact(mk(BSPS_CMD_ACK, 0, 0, 0), mk(BSPS_CMD_ACK, 2, {8'h00, VER}, 0));
	endtask
	task automatic t_sets();
		logic [7:0] codes [6] = '{8'hf0, 8'hc0, 8'he0, 8'hf1, 8'hf2, 8'hf3};
		logic [15:0] v;
		int n0;
		foreach (codes[i]) begin
			v = 16'h8001 + 16'(i * 3);
			n0 = stb_cnt;
			xact(mk(codes[i], 2, {8'h00, v}, 0), mk(codes[i], 3, {pqual[8*(i+2)+:8], v}, 0));
			check(stb_cnt - n0, 1);
			check({idx, sval}, {3'(i + 2), v});
		end
	endtask
	task automatic t_errors();
		int n0;
		n0 = stb_cnt;
		xact(mk(8'h20, 0, 0, 1), err(BSPS_ERR_BADSUM, 8'h20));
		xact(mk(8'h55, 0, 0, 1), err(BSPS_ERR_BADSUM, 8'h55));
		xact(mk(8'h55, 0, 0, 0), err(BSPS_ERR_BADCMD, 8'h55));
		xact(mk(8'ha0, 2, 24'h000001, 0), err(BSPS_ERR_BADCMD, 8'ha0));
		xact(mk(8'h70, 1, 24'h000011, 0), err(BSPS_ERR_BADCMD, 8'h70));
		xact(mk(8'hf0, 3, 24'h110001, 1), err(BSPS_ERR_BADSUM, 8'hf0));
		check(stb_cnt, n0);
	endtask
	task automatic t_resync();
		bsps_bytes_t junk;
		junk = {8'h55, 8'h00, BSPS_LEAD, 8'h01, BSPS_LEAD, BSPS_ADDR_HI, 8'h02,
			BSPS_LEAD, BSPS_ADDR_HI, BSPS_ADDR_LO, 8'h20, 8'h05};
		xact({junk, mk(8'h70, 0, 0, 0)}, mk(8'h70, 3, {pqual[23:16], pval[47:32]}, 0));
		host_u.send({BSPS_LEAD, BSPS_ADDR_HI});
		repeat (RETRY + 100) @(negedge clk);
		xact(mk(8'h21, 0, 0, 0), mk(8'h21, 3, {pqual[15:8], pval[31:16]}, 0));
	endtask
	task automatic t_disabled();
		int n0;
		n0 = stb_cnt;
		@(negedge clk);
		en = 1'b0;
		host_u.send({mk(8'h20, 0, 0, 0), mk(8'hf0, 2, 24'h000123, 0)});
		host_u.recv();
		check(host_u.rx_q.size(), 0);
		check(stb_cnt, n0);
		en = 1'b1;
		xact(mk(8'h20, 0, 0, 0), mk(8'h20, 3, {pqual[7:0], pval[15:0]}, 0));
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 8; i++) begin
			pval[16*i+:16] = 16'hff97 + 16'(i * 257);
			pqual[8*i+:8] = (i % 3 == 0) ? BSPS_QUAL_P1_C : ((i % 3 == 1) ? BSPS_QUAL_P1 : BSPS_QUAL_P01);
		end
		repeat (3) @(negedge clk);
		check({txd, stb, idx, sval}, {1'b1, 1'b0, 3'h0, 16'h0000});
		rst_b = 1'b1;
		t_reads();
		t_sets();
		t_errors();
		t_resync();
		t_disabled();
		stop_test();
	end
	initial begin
		#450000;
		mismatches++;
		stop_test();
	end
endmodule
`default_nettype wire
